// ---- rtl/status_led_defs.svh ----
/*
  Constants for the controller status LED encoder: clock rate, flash and
  burst timing, error classes, register offsets and field positions.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef STATUS_LED_DEFS_SVH
`define STATUS_LED_DEFS_SVH

// Clock and derived time base
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define TICK_CYC (`CLK_HZ / `MS_PER_S)

// Times in milliseconds; pause length in pulse slots
`define FLASH_HALF_MS 500
`define PULSE_HALF_MS 250
`define BURST_PAUSE_MS 1000
`define NET_FLASH_MS 3000
`define OV36_HOLD_MS 1000
`define PAUSE_SLOTS (`BURST_PAUSE_MS / `PULSE_HALF_MS)

// Error classes, equal to the pulse count of the burst
`define ERR_CLASS_CFG 4'h2
`define ERR_CLASS_APP 4'h3
`define ERR_CLASS_SELFTEST 4'h4
`define ERR_CLASS_SUPPLY 4'h5
`define ERR_CLASS_IO 4'h6
`define ERR_CLASS_XCOMM 4'h7
`define ERR_CLASS_INTERNAL 4'h8

// Supply index in monitor vectors
`define SUP_LOGIC 0
`define SUP_GROUP1 1
`define SUP_GROUP2 2

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_OUT_CMD 8'h08
`define REG_IN_CFG 8'h0C

// CTRL fields
`define CTRL_VERIFY_BIT 0
`define CTRL_START_BIT 1
`define CTRL_STOP_BIT 2
`define CTRL_NET_BIT 3

// STATUS fields
`define STAT_STATE_LSB 0
`define STAT_ERROR_BIT 2
`define STAT_CLASS_LSB 4
`define STAT_OUT_OK_BIT 8

// IN_CFG fields
`define INCFG_DUAL_LSB 16

`endif

// ---- rtl/status_led_pkg.sv ----
/*
  Types for the controller status LED encoder.
  Assumes status_led_defs.svh is on the include path.
*/
package status_led_pkg;
  `include "status_led_defs.svh"

  typedef enum logic [1:0] {
    ST_NOPROJ,
    ST_STOP,
    ST_RUN,
    ST_ERROR
  } run_state_t;
endpackage : status_led_pkg

// ---- rtl/flash_if.sv ----
/*
  Carrier of the shared flash time base between the divider and the
  LED encoder. Assumes one clock domain on both sides.
*/
`timescale 1ns/1ps
interface flash_if;
  logic ms_tick;
  logic flash_phase;

  modport source (output ms_tick, output flash_phase);
  modport user (input ms_tick, input flash_phase);
endinterface : flash_if

// ---- rtl/flash_timebase.sv ----
/*
  Single divider for every flash pattern: a millisecond tick and a 1 Hz
  square wave with 50 percent duty. Assumes clk at the rate of CLK_HZ.
*/
`timescale 1ns/1ps
`include "status_led_defs.svh"
module flash_timebase #(
  parameter int TICK_CYC = `TICK_CYC,
  parameter int HALF_MS = `FLASH_HALF_MS
) (
  input wire logic clk,
  input wire logic sys_rst,
  flash_if.source tb
);
  import status_led_pkg::*;

  logic [24:0] pre_r;
  logic [11:0] half_r;

  // Prescaler down to one pulse per millisecond
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= 25'h0000000;
      tb.ms_tick <= 1'b0;
    end else if (pre_r == 25'(TICK_CYC - 1)) begin
      pre_r <= 25'h0000000;
      tb.ms_tick <= 1'b1;
    end else begin
      pre_r <= pre_r + 25'h0000001;
      tb.ms_tick <= 1'b0;
    end
  end

  // One phase for all LEDs so synchronous and alternating ones line up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_r <= 12'h000;
      tb.flash_phase <= 1'b0;
    end else if (tb.ms_tick) begin
      if (half_r == 12'(HALF_MS - 1)) begin
        half_r <= 12'h000;
        tb.flash_phase <= ~tb.flash_phase;
      end else begin
        half_r <= half_r + 12'h001;
      end
    end
  end
endmodule : flash_timebase

// ---- rtl/controller_status_led_encoder.sv ----
/*
  Status LED encoder of a safety controller: error latch with pulse-count
  burst, supply indication, run state with automatic start, verified,
  network, input and output LEDs, and a small register port.
  Assumes supply monitor and terminal levels arrive asynchronously, all
  other flags from logic on clk, and sys_rst is the power-on reset.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "status_led_defs.svh"
// How it works
// - Any controller error switches all 24 V outputs off and flashes power LED red.
// - In error the red power LED bursts a pulse count equal to error class.
// - The error state is left only through power-on reset.
// - Any supply below 16.8 V, or a group supply above 30 V, flashes the power LED green.
// - Group overvoltage counts only if an output of that group is configured.
// - Logic overvoltage above 30 V, or 36 V over 1 s, raises class 5.
// - All supplies good and no error gives steady green power LED.
// - Module LED flashes red without a project or with faulty project data.
// - Module LED flashes green while stopped, steady green when running.
// - Input, sequence or output test errors flash module LED red and green alternately.
// - Unverified project flashes verified LED yellow and needs an external start.
// - Verified project lights verified LED steady and starts by itself after reset.
// - Connection set-up flashes the network LED green for 3 s.
// - Single-channel input error or unconfigured live input flashes in step with red.
// - Dual-channel pair error flashes the pair's two LEDs alternately.
// - Without error an input LED follows its terminal level.
// - An output or combined channel with a test error flashes green.
module controller_status_led_encoder #(
  parameter int N_IN = 8,
  parameter int N_OUT = 4,
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] supply_under,
  input wire logic [2:0] supply_over,
  input wire logic logic_supply_ov36,
  input wire logic [N_IN-1:0] safe_input_channel,
  input wire logic err_event,
  input wire logic [3:0] err_class,
  input wire logic project_present,
  input wire logic project_faulty,
  input wire logic verified_nv,
  input wire logic [N_IN-1:0] in_test_err,
  input wire logic [N_IN/2-1:0] pair_seq_err,
  input wire logic [N_OUT-1:0] out_test_err,
  output logic [N_OUT-1:0] safe_output_channel,
  output logic power_error_red,
  output logic power_error_green,
  output logic module_state_red,
  output logic module_state_green,
  output logic config_verified_indicator,
  output logic network_status_indicator,
  output logic [N_IN-1:0] input_led,
  output logic [N_OUT-1:0] output_led
);
  import status_led_pkg::*;

  localparam int NS = 3 + 1 + N_IN; // Monitor flags, ov36, terminals

  flash_if fl ();
  flash_timebase #(.TICK_CYC(TICK_CYC), .HALF_MS(`FLASH_HALF_MS)) u_tb (
    .clk(clk),
    .sys_rst(sys_rst),
    .tb(fl.source)
  );

  function automatic logic [3:0] clamp_class(input logic [3:0] c);
    // Unknown class codes shown as internal error rather than lost
    clamp_class = (c < `ERR_CLASS_CFG || c > `ERR_CLASS_INTERNAL) ?
                  `ERR_CLASS_INTERNAL : c;
  endfunction : clamp_class

  // Asynchronous pins: three stages, accepted when the last two agree
  logic [NS-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [NS-1:0] raw;
  assign raw = {safe_input_channel, logic_supply_ov36, supply_under | supply_over};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    end
  end

  // Over-range flags kept apart so group overvoltage can be masked
  logic [2:0] ov1_r, ov2_r, ov3_r, ovf_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov1_r <= 3'h0;
      ov2_r <= 3'h0;
      ov3_r <= 3'h0;
      ovf_r <= 3'h0;
    end else begin
      ov1_r <= supply_over;
      ov2_r <= ov1_r;
      ov3_r <= ov2_r;
      ovf_r <= (ov2_r & ov3_r) | (ovf_r & (ov2_r | ov3_r));
    end
  end

  logic [2:0] sup_bad;
  logic ov36_f;
  logic [N_IN-1:0] level_f;
  assign sup_bad = filt_r[2:0];
  assign ov36_f = filt_r[3];
  assign level_f = filt_r[NS-1:4];

  // Registers
  logic verified_r;
  logic [N_OUT-1:0] out_cmd_r;
  logic [N_IN-1:0] in_cfg_r;
  logic [N_IN/2-1:0] dual_r;
  logic start_cmd, stop_cmd, net_go;
  logic wr_ctrl;
  assign wr_ctrl = reg_wr && reg_addr == `REG_CTRL;
  assign start_cmd = wr_ctrl && reg_wdata[`CTRL_START_BIT];
  assign stop_cmd = wr_ctrl && reg_wdata[`CTRL_STOP_BIT];
  assign net_go = wr_ctrl && reg_wdata[`CTRL_NET_BIT];

  // Verified flag taken from storage once after reset, set by software
  logic boot_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_r <= 1'b1;
      verified_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      if (boot_r)
        verified_r <= verified_nv;
      else if (wr_ctrl && reg_wdata[`CTRL_VERIFY_BIT])
        verified_r <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_cmd_r <= '0;
      in_cfg_r <= '0;
      dual_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_OUT_CMD)
        out_cmd_r <= reg_wdata[N_OUT-1:0];
      if (reg_addr == `REG_IN_CFG) begin
        in_cfg_r <= reg_wdata[N_IN-1:0];
        dual_r <= reg_wdata[`INCFG_DUAL_LSB +: N_IN/2];
      end
    end
  end

  // Logic supply held above 36 V for the hold time
  logic [11:0] ov36_ms_r;
  logic ov36_crit;
  assign ov36_crit = ov36_ms_r == 12'(`OV36_HOLD_MS);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ov36_ms_r <= 12'h000;
    else if (!ov36_f)
      ov36_ms_r <= 12'h000;
    else if (fl.ms_tick && !ov36_crit)
      ov36_ms_r <= ov36_ms_r + 12'h001;
  end

  // Run state with automatic start; error is absorbing
  run_state_t state_r;
  logic auto_r;
  logic [3:0] class_r;
  logic crit;
  logic proj_ok;
  assign crit = ovf_r[`SUP_LOGIC] || ov36_crit;
  assign proj_ok = project_present && !project_faulty;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_NOPROJ;
      auto_r <= 1'b1;
      class_r <= 4'h0;
    end else if (state_r != ST_ERROR && (err_event || crit)) begin
      state_r <= ST_ERROR;
      class_r <= err_event ? clamp_class(err_class) : `ERR_CLASS_SUPPLY;
    end else if (!boot_r) begin
      unique case (state_r)
        ST_NOPROJ: if (proj_ok) begin
          auto_r <= 1'b0;
          state_r <= (auto_r && verified_r) ? ST_RUN : ST_STOP;
        end
        ST_STOP: if (!proj_ok) state_r <= ST_NOPROJ;
          else if (start_cmd) state_r <= ST_RUN;
        ST_RUN: if (!proj_ok) state_r <= ST_NOPROJ;
          else if (stop_cmd) state_r <= ST_STOP;
        ST_ERROR: state_r <= ST_ERROR;
      endcase
    end
  end

  logic err;
  assign err = state_r == ST_ERROR;

  // Outputs released only while running and free of error
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      safe_output_channel <= '0;
    else
      safe_output_channel <= (state_r == ST_RUN && !err) ? out_cmd_r : '0;
  end

  // Burst slots: 2*class lit/dark halves, then a long dark pause
  logic [4:0] slot_r;
  logic [11:0] slot_ms_r;
  logic [4:0] slot_end;
  assign slot_end = 5'({class_r, 1'b0}) + 5'(`PAUSE_SLOTS);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_r <= 5'h00;
      slot_ms_r <= 12'h000;
    end else if (!err) begin
      slot_r <= 5'h00;
      slot_ms_r <= 12'h000;
    end else if (fl.ms_tick) begin
      if (slot_ms_r == 12'(`PULSE_HALF_MS - 1)) begin
        slot_ms_r <= 12'h000;
        slot_r <= (slot_r == slot_end - 5'h01) ? 5'h00 : slot_r + 5'h01;
      end else begin
        slot_ms_r <= slot_ms_r + 12'h001;
      end
    end
  end

  logic burst_on;
  assign burst_on = slot_r < 5'({class_r, 1'b0}) && !slot_r[0];

  // Supply view: group overvoltage ignored when group has no outputs
  logic [2:0] sup_show;
  logic g1_used, g2_used;
  assign g1_used = |out_cmd_r[N_OUT/2-1:0];
  assign g2_used = |out_cmd_r[N_OUT-1:N_OUT/2];
  assign sup_show = sup_bad & ~(ovf_r & {!g2_used, !g1_used, 1'b0});

  // Power/error LED
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_error_red <= 1'b0;
      power_error_green <= 1'b0;
    end else if (err) begin
      power_error_red <= burst_on;
      power_error_green <= 1'b0;
    end else begin
      power_error_red <= 1'b0;
      power_error_green <= (|sup_show) ? fl.flash_phase : 1'b1;
    end
  end

  // Module-state LED; repairable errors take precedence over run state
  logic repair;
  logic [N_IN-1:0] single_err;
  logic [N_IN-1:0] pair_err;
  logic [N_IN-1:0] dual_bits;
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      dual_bits[i] = dual_r[i/2];
      pair_err[i] = pair_seq_err[i/2] || in_test_err[i & ~1] || in_test_err[i | 1];
      single_err[i] = in_test_err[i] || (!in_cfg_r[i] && level_f[i]);
    end
  end
  assign repair = |(in_test_err | (pair_err & dual_bits)) || (|out_test_err);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_state_red <= 1'b0;
      module_state_green <= 1'b0;
    end else if (err) begin
      module_state_red <= 1'b1;
      module_state_green <= 1'b0;
    end else if (repair) begin
      module_state_red <= fl.flash_phase;
      module_state_green <= ~fl.flash_phase;
    end else begin
      unique case (state_r)
        ST_NOPROJ: begin
          module_state_red <= fl.flash_phase;
          module_state_green <= 1'b0;
        end
        ST_STOP: begin
          module_state_red <= 1'b0;
          module_state_green <= fl.flash_phase;
        end
        default: begin
          module_state_red <= 1'b0;
          module_state_green <= 1'b1;
        end
      endcase
    end
  end

  // Verified LED
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      config_verified_indicator <= 1'b0;
    else
      config_verified_indicator <= verified_r ? 1'b1 : fl.flash_phase;
  end

  // Network LED: fixed window after each connection set-up
  logic [11:0] net_ms_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      net_ms_r <= 12'h000;
      network_status_indicator <= 1'b0;
    end else begin
      if (net_go)
        net_ms_r <= 12'(`NET_FLASH_MS);
      else if (fl.ms_tick && net_ms_r != 12'h000)
        net_ms_r <= net_ms_r - 12'h001;
      network_status_indicator <= (net_ms_r != 12'h000) && fl.flash_phase;
    end
  end

  // Input and output LEDs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_led <= '0;
      output_led <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (dual_bits[i] && pair_err[i])
          input_led[i] <= fl.flash_phase ^ i[0];
        else if (!dual_bits[i] && single_err[i])
          input_led[i] <= fl.flash_phase;
        else
          input_led[i] <= level_f[i];
      end
      for (int j = 0; j < N_OUT; j++)
        output_led[j] <= out_test_err[j] ? fl.flash_phase : safe_output_channel[j];
    end
  end

  // Read port, data valid in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: reg_rdata <= 32'(verified_r) << `CTRL_VERIFY_BIT;
        `REG_STATUS: reg_rdata <= (32'(state_r) << `STAT_STATE_LSB)
                                | (32'(err) << `STAT_ERROR_BIT)
                                | (32'(class_r) << `STAT_CLASS_LSB)
                                | (32'(|safe_output_channel) << `STAT_OUT_OK_BIT);
        `REG_OUT_CMD: reg_rdata <= 32'(out_cmd_r);
        `REG_IN_CFG: reg_rdata <= 32'(in_cfg_r) | (32'(dual_r) << `INCFG_DUAL_LSB);
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_outputs_off: assert property (err |=> safe_output_channel == '0 ##1 safe_output_channel == '0) else $error("outputs live in error");
  chk_error_sticky: assert property (err |=> err && $stable(class_r)) else $error("error state left");
  chk_burst_lit: assert property (err && burst_on |=> power_error_red) else $error("burst pulse missing");
  chk_pause_dark: assert property (err && slot_r >= 5'({class_r, 1'b0}) |=> !power_error_red) else $error("lit during pause");
  chk_green_steady: assert property (!err && sup_show == 3'h0 |=> power_error_green && !power_error_red) else $error("power not steady green");
  chk_supply_flash: assert property (!err && |sup_show |=> power_error_green == $past(fl.flash_phase)) else $error("supply flash wrong");
  chk_ms_alternate: assert property (!err && repair |=> module_state_red != module_state_green) else $error("module LED not alternating");
  chk_auto_start: assert property (state_r == ST_NOPROJ && auto_r && verified_r && proj_ok && !boot_r && !err_event && !crit |=> state_r == ST_RUN) else $error("no automatic start");
  chk_no_auto_run: assert property (state_r == ST_NOPROJ && !verified_r && proj_ok && !boot_r && !err_event && !crit |=> state_r == ST_STOP) else $error("unverified project ran");
  chk_net_window: assert property (net_go |=> net_ms_r == 12'(`NET_FLASH_MS)) else $error("network window not loaded");
endmodule : controller_status_led_encoder

// ---- tb/led_panel_observer.sv ----
/*
  Operator at the front panel: counts the pulses of one lamp and reports
  the count when a dark gap ends the burst. Assumes a registered lamp on clk.
*/
`timescale 1ns/1ps
module led_panel_observer #(
  parameter int DARK_CYC = 750
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lamp,
  output logic [3:0] burst_count,
  output logic burst_seen
);
  logic lamp_r;
  logic [3:0] pulse_r;
  int dark_r;

  // Gap longer than one pulse period closes a burst; empty gaps not reported
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lamp_r <= 1'b0;
      pulse_r <= 4'h0;
      dark_r <= 0;
      burst_count <= 4'h0;
      burst_seen <= 1'b0;
    end else begin
      lamp_r <= lamp;
      burst_seen <= 1'b0;
      dark_r <= lamp ? 0 : dark_r + 1;
      if (lamp && !lamp_r) begin
        pulse_r <= pulse_r + 4'h1;
      end else if (dark_r == DARK_CYC && pulse_r != 4'h0) begin
        burst_count <= pulse_r;
        burst_seen <= 1'b1;
        pulse_r <= 4'h0;
      end
    end
  end
endmodule : led_panel_observer

// ---- tb/testbench.sv ----
/*
  Self-checking bench of the status LED encoder: register port, LED codes
  and error bursts. Assumes the time base shortened to one cycle per ms.
*/
`timescale 1ns/1ps
module testbench;
  import status_led_pkg::*;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, err_event = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] supply_under = 3'h0, supply_over = 3'h0;
  logic [7:0] levels = 8'h00, in_test_err = 8'h00, input_led;
  logic [3:0] err_class = 4'h0, pair_seq_err = 4'h0, out_test_err = 4'h0;
  logic [3:0] safe_output_channel, output_led, burst_count;
  logic project_present = 0, verified_nv = 0, burst_seen, rd_seen = 0;
  logic ov36 = 0, project_faulty = 0;
  int k;
  logic power_error_red, power_error_green, module_state_red, module_state_green;
  logic config_verified_indicator, network_status_indicator;
  logic [17:0] leds;
  logic [31:0] exp_q[$];
  int fails = 0, comparisons = 0, cycles = 0, seed;
  localparam int IN0 = 4, IN2 = 6, NETWORK_STATUS_INDICATOR = 12, CV = 13, MSG = 14, MSR = 15, PEG = 16;

  assign leds = {power_error_red, power_error_green, module_state_red, module_state_green,
    config_verified_indicator, network_status_indicator, input_led, output_led};

  always #25 clk = ~clk;

  controller_status_led_encoder #(.TICK_CYC(1)) controller_status_led_encoder_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_under(supply_under), .supply_over(supply_over), .logic_supply_ov36(ov36),
    .safe_input_channel(levels), .err_event(err_event), .err_class(err_class),
    .project_present(project_present), .project_faulty(project_faulty),
    .verified_nv(verified_nv),
    .in_test_err(in_test_err), .pair_seq_err(pair_seq_err), .out_test_err(out_test_err),
    .safe_output_channel(safe_output_channel), .power_error_red(power_error_red),
    .power_error_green(power_error_green), .module_state_red(module_state_red),
    .module_state_green(module_state_green),
    .config_verified_indicator(config_verified_indicator),
    .network_status_indicator(network_status_indicator), .input_led(input_led),
    .output_led(output_led));

  led_panel_observer led_panel_observer_i (.clk(clk), .sys_rst(sys_rst),
    .lamp(power_error_red), .burst_count(burst_count), .burst_seen(burst_seen));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Strobes drop after one cycle and a quiet cycle follows
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(2);
  endtask : rd

  // Waits for an edge of the lamp, then looks a half period apart
  task flashes(input int i);
    logic a;
    int n;
    a = leds[i];
    n = 0;
    while (leds[i] === a && n < 1200) begin
      tick(1);
      n++;
    end
    tick(250);
    a = leds[i];
    tick(500);
    check(32'(leds[i] ^ a), 32'h1);
  endtask : flashes

  task steady(input int i, input logic v);
    repeat (3) begin
      tick(400);
      check(32'(leds[i]), 32'(v));
    end
  endtask : steady

  task wait_burst;
    int n;
    n = 0;
    while (burst_seen !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    tick(1);
  endtask : wait_burst

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end

  // Hang guard, sized above the longest error bursts
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    seed = $urandom(32'hDBBF3386);
    tick(2);
    check(32'({leds, safe_output_channel}), 32'h0);
    tick(3);
    sys_rst <= 1'b0;
    tick(10);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    flashes(MSR);
    flashes(CV);
    steady(PEG, 1'b1);
    project_present <= 1'b1;
    project_faulty <= 1'b1;
    tick(5);
    rd(8'h04, 32'h0);
    project_faulty <= 1'b0;
    tick(5);
    rd(8'h04, 32'h1);
    flashes(MSG);
    wr(8'h0C, 32'h0002_00FF);
    wr(8'h08, 32'hF);
    rd(8'h08, 32'hF);
    wr(8'h00, 32'h2);
    tick(3);
    rd(8'h04, 32'h102);
    check(32'(safe_output_channel), 32'hF);
    check(32'(output_led), 32'hF);
    steady(MSG, 1'b1);
    levels <= 8'($urandom);
    tick(10);
    check(32'(input_led), 32'(levels));
    in_test_err <= 8'h01;
    flashes(IN0);
    check(32'(input_led[0]), 32'(module_state_red));
    check(32'(module_state_red ^ module_state_green), 32'h1);
    in_test_err <= 8'h00;
    pair_seq_err <= 4'h2;
    flashes(IN2);
    check(32'(input_led[2] ^ input_led[3]), 32'h1);
    pair_seq_err <= 4'h0;
    out_test_err <= 4'h4;
    flashes(2);
    out_test_err <= 4'h0;
    supply_under <= 3'h1;
    flashes(PEG);
    supply_under <= 3'h0;
    supply_over <= 3'h2;
    flashes(PEG);
    wr(8'h08, 32'hC);
    steady(PEG, 1'b1);
    supply_over <= 3'h0;
    wr(8'h00, 32'h8);
    flashes(NETWORK_STATUS_INDICATOR);
    tick(3000);
    check(32'(network_status_indicator), 32'h0);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    steady(CV, 1'b1);
    verified_nv <= 1'b1;
    // Class 5 twice: 36 V held past its hold time, then plain logic overvoltage
    for (int c = 2; c <= 9; c++) begin
      k = (c == 9) ? 5 : c;
      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      tick(5);
      rd(8'h04, 32'h2);
      wr(8'h08, 32'hF);
      tick(3);
      check(32'(safe_output_channel), 32'hF);
      if (c == 9) supply_over <= 3'h1;
      else if (c == 5) begin
        ov36 <= 1'b1;
        tick(990);
        check(32'(safe_output_channel), 32'hF);
        tick(30);
      end else begin
        err_class <= (c == 8) ? 4'hF : 4'(c);
        err_event <= 1'b1;
        tick(1);
        err_event <= 1'b0;
      end
      tick(10);
      check(32'(safe_output_channel), 32'h0);
      check(32'(power_error_green), 32'h0);
      supply_over <= 3'h0;
      ov36 <= 1'b0;
      wr(8'h00, 32'h2);
      rd(8'h04, 32'h7 | (32'(k) << 4));
      wait_burst();
      wait_burst();
      check(32'(burst_count), 32'(k));
    end
    test_done();
  end
endmodule : testbench
